/* File: hdl/mul_interlock_pkg.sv */
// shared constants for the multiplier pipeline interlock
package mul_interlock_pkg;
   localparam int unsigned OPCLASS_W      = 4;
   localparam int unsigned MM_CYCLES      = 4;
   localparam int unsigned DOUBLE_MA_CNT  = 2;
   localparam int unsigned DECODE_HOLD    = 1;
   localparam int unsigned MM_CNT_W       = 3;

   typedef enum logic [OPCLASS_W-1:0] {
      OP_PLAIN                      = 4'h0,
      OP_DOUBLE_SIGNED_MULTIPLY     = 4'h1,
      OP_DOUBLE_UNSIGNED_MULTIPLY   = 4'h2,
      OP_LONG_PRODUCT_MULTIPLY      = 4'h3,
      OP_WORD_SIGNED_MULTIPLY       = 4'h4,
      OP_LONG_MULTIPLY_ACCUMULATE   = 4'h5,
      OP_WORD_MULTIPLY_ACCUMULATE   = 4'h6,
      OP_ACCUMULATOR_STORE_TO_REG   = 4'h7,
      OP_ACCUMULATOR_STORE_TO_MEM   = 4'h8,
      OP_ACCUMULATOR_LOAD_FROM_REG  = 4'h9,
      OP_ACCUMULATOR_LOAD_FROM_MEM  = 4'hA
   } opclass_t;

   // memory-access sequencer states, one bit changes per step except MA_SECOND back to MA_IDLE
   typedef enum logic [1:0] {
      MA_IDLE   = 2'b00,
      MA_FIRST  = 2'b01,
      MA_SECOND = 2'b11,
      MA_WAIT   = 2'b10
   } ma_state_t;
endpackage

/* File: hdl/mm_countdown.sv */
// multiplier-busy countdown, loaded when the access stages end
`timescale 1ns/1ps
module mm_countdown
   import mul_interlock_pkg::*;
#(
   parameter int unsigned CYCLES = MM_CYCLES
) (
   input  wire logic                sys_clk,    // system clock
   input  wire logic                sys_rst,    // async reset, high
   input  wire logic                load,       // access stages ended
   output logic                     busy,       // multiplier operating
   output logic [MM_CNT_W-1:0]      remaining   // cycles left
);
   initial begin
      if (CYCLES == 0 || CYCLES >= (1 << MM_CNT_W))
         $error("mm_countdown: CYCLES out of range");
   end

   typedef struct packed {
      logic [MM_CNT_W-1:0] cnt;
   } cd_state_t;

   cd_state_t st;
   cd_state_t next_st;

   always_comb begin
      next_st = st;
      if (load) begin
         next_st.cnt = MM_CNT_W'(CYCLES);
      end else if (st.cnt != '0) begin
         next_st.cnt = st.cnt - MM_CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy      = (st.cnt != '0);
   assign remaining = st.cnt;
endmodule

/* File: hdl/mul_interlock.sv */
// interlock between decode/fetch and the shared multiplier
//
// Functional notes
// - accumulator load from memory gets an extra multiplier-access stage
// - that access stretches until multiplier idle, counted as one slot
// - accumulator-load access competes with fetch through fetch/access arbitration
// - double multiply: fetch, decode, execute, two accesses, four operating stages
// - operands handed to the multiplier during the access stages
// - multiplier runs four cycles after access, ignoring stalls
// - decode of the instruction after double multiply holds through the first access and while any access waits for the bus
// - double multiply accesses split the slot with a colliding fetch
// - no interlock when the next instruction does not use the multiplier
// - interlock applies to multiply, accumulate and accumulator transfer followers
// - three double multiplies: signed, unsigned, and 32-bit product
`timescale 1ns/1ps
module mul_interlock
   import mul_interlock_pkg::*;
(
   input  wire logic                 sys_clk,          // system clock 200 MHz
   input  wire logic                 sys_rst,          // async reset, high
   input  wire logic                 ex_valid,         // instruction enters execute
   input  wire logic [OPCLASS_W-1:0] ex_opclass,       // its class
   input  wire logic [31:0]          ex_op_a,          // operand a
   input  wire logic [31:0]          ex_op_b,          // operand b
   input  wire logic                 fetch_req,        // fetch wants the bus
   input  wire logic                 bus_ready,        // bus finishes current cycle
   output logic                      decode_stall,     // hold decode stage
   output logic                      ma_active,        // access stage in progress
   output logic                      bus_grant_ma,     // bus given to access
   output logic                      bus_grant_fetch,  // bus given to fetch
   output logic                      mul_start,        // pulse: operands loaded
   output logic                      mul_signed,       // signed operation
   output logic                      mul_long_result,  // 64-bit result wanted
   output logic [31:0]               mul_a,            // operand a to multiplier
   output logic [31:0]               mul_b,            // operand b to multiplier
   output logic                      mul_busy,         // multiplier operating
   output logic                      acc_access        // single-access (MA_WAIT) completion strobe
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic is_double(input logic [OPCLASS_W-1:0] c);
      return c == OP_DOUBLE_SIGNED_MULTIPLY || c == OP_DOUBLE_UNSIGNED_MULTIPLY
             || c == OP_LONG_PRODUCT_MULTIPLY;
   endfunction

   function automatic logic uses_mul(input logic [OPCLASS_W-1:0] c);
      return is_double(c) || c == OP_WORD_SIGNED_MULTIPLY
             || c == OP_LONG_MULTIPLY_ACCUMULATE || c == OP_WORD_MULTIPLY_ACCUMULATE
             || c == OP_ACCUMULATOR_STORE_TO_REG || c == OP_ACCUMULATOR_STORE_TO_MEM
             || c == OP_ACCUMULATOR_LOAD_FROM_REG
             || c == OP_ACCUMULATOR_LOAD_FROM_MEM;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      ma_state_t              ma;
      logic [OPCLASS_W-1:0]   cls;
      logic                   fetch_turn;
      logic                   hold;
      logic                   start;
      logic                   sgn;
      logic                   lng;
      logic [31:0]            a;
      logic [31:0]            b;
      logic                   acc;
   } il_state_t;

   il_state_t st;
   il_state_t next_st;
   logic      mm_load;
   logic      mm_busy;
   logic      can_access;
   logic      grant_ma;
   logic      grant_fetch;

   mm_countdown #(.CYCLES(MM_CYCLES)) u_countdown (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .load      (mm_load),
      .busy      (mm_busy),
      .remaining ()
   );

   // ------------------------------------------------------------
   // arbitration: an access may not start while the multiplier runs
   // ------------------------------------------------------------
   always_comb begin
      can_access  = (st.ma != MA_IDLE) && !mm_busy;
      // alternate on collision so the slot is split between access and fetch
      grant_ma    = can_access && (!fetch_req || !st.fetch_turn);
      grant_fetch = fetch_req && !grant_ma;
      mm_load     = grant_ma && bus_ready && st.ma == MA_SECOND;
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_st       = st;
      next_st.start = 1'b0;
      next_st.acc   = 1'b0;
      next_st.hold  = 1'b0;
      if (fetch_req && bus_ready && (grant_ma || grant_fetch)) begin
         next_st.fetch_turn = grant_ma;
      end
      case (st.ma)
         MA_IDLE: begin
            if (ex_valid && uses_mul(ex_opclass)) begin
               next_st.cls = ex_opclass;
               next_st.a   = ex_op_a;
               next_st.b   = ex_op_b;
               next_st.sgn = ex_opclass == OP_DOUBLE_SIGNED_MULTIPLY;
               next_st.lng = ex_opclass != OP_LONG_PRODUCT_MULTIPLY;
               // single accesses (incl. accumulator load from memory) use MA_WAIT
               next_st.ma  = is_double(ex_opclass) ? MA_FIRST : MA_WAIT;
               next_st.hold = is_double(ex_opclass);
            end
         end
         MA_FIRST: begin
            if (grant_ma && bus_ready) begin
               next_st.ma    = MA_SECOND;
               next_st.start = 1'b1;
            end
         end
         MA_SECOND: begin
            if (grant_ma && bus_ready) begin
               next_st.ma = MA_IDLE;
            end
         end
         MA_WAIT: begin
            // stretched access: completes as one slot once multiplier idle
            if (grant_ma && bus_ready) begin
               next_st.acc = 1'b1;
               next_st.ma  = MA_IDLE;
            end
         end
         default: next_st.ma = MA_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign decode_stall    = st.hold || (st.ma != MA_IDLE && !grant_ma) || (st.ma == MA_FIRST);
   assign ma_active       = st.ma != MA_IDLE;
   assign bus_grant_ma    = grant_ma;
   assign bus_grant_fetch = grant_fetch;
   assign mul_start       = st.start;
   assign mul_signed      = st.sgn;
   assign mul_long_result = st.lng;
   assign mul_a           = st.a;
   assign mul_b           = st.b;
   assign mul_busy        = mm_busy;
   assign acc_access      = st.acc;
endmodule

/* File: verif/mul_interlock_assertions.sv */
// port checker for the multiplier interlock
`timescale 1ns/1ps
module mul_interlock_assertions
   import mul_interlock_pkg::*;
(
   input wire logic                 sys_clk,         // clk
   input wire logic                 sys_rst,         // rst
   input wire logic                 ex_valid,        // in
   input wire logic [OPCLASS_W-1:0] ex_opclass,      // in
   input wire logic                 fetch_req,       // in
   input wire logic                 bus_ready,       // in
   input wire logic                 decode_stall,    // out
   input wire logic                 ma_active,       // out
   input wire logic                 bus_grant_ma,    // out
   input wire logic                 bus_grant_fetch, // out
   input wire logic                 mul_start,       // out
   input wire logic                 mul_busy,        // out
   input wire logic                 acc_access       // out
);
   logic acc_q;
   wire  dbl = ex_valid && !ma_active && ex_opclass != 4'h0 && ex_opclass < 4'h4;
   // access completed in the previous cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) acc_q <= 1'b0;
      else acc_q <= bus_grant_ma && bus_ready;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_excl; !(bus_grant_ma && bus_grant_fetch); endproperty
   a_excl: assert property (p_excl) else $error("both grants high");
   property p_wait; bus_grant_ma |-> !mul_busy; endproperty
   a_wait: assert property (p_wait) else $error("access granted while busy");
   property p_busy4; $rose(mul_busy) |-> mul_busy[*4] ##1 !mul_busy; endproperty
   a_busy4: assert property (p_busy4) else $error("busy not four cycles");
   property p_issue; dbl |=> ma_active && decode_stall; endproperty
   a_issue: assert property (p_issue) else $error("double issue not held");
   property p_start; mul_start |-> acc_q && ma_active; endproperty
   a_start: assert property (p_start) else $error("start not after first access");
   property p_bsrc; $rose(mul_busy) |-> acc_q && !ma_active; endproperty
   a_bsrc: assert property (p_bsrc) else $error("busy not after last access");
   property p_plain; ex_valid && !ma_active && ex_opclass == 4'h0 |=> !ma_active; endproperty
   a_plain: assert property (p_plain) else $error("plain class interlocked");
   property p_single; acc_access |-> acc_q && !ma_active; endproperty
   a_single: assert property (p_single) else $error("access strobe early");
   property p_fetch; !ma_active && fetch_req |-> bus_grant_fetch; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch not granted");
endmodule
bind mul_interlock mul_interlock_assertions i_chk (.sys_clk, .sys_rst, .ex_valid, .ex_opclass,
   .fetch_req, .bus_ready, .decode_stall, .ma_active, .bus_grant_ma, .bus_grant_fetch,
   .mul_start, .mul_busy, .acc_access);

/* File: verif/testbench.sv */
// self-checking bench for the multiplier interlock
`timescale 1ns/1ps
module testbench;
   import mul_interlock_pkg::*;
   logic        sys_clk, sys_rst, ex_valid, fetch_req, bus_ready;
   logic [3:0]  ex_opclass;
   logic [31:0] ex_op_a, ex_op_b, mul_a, mul_b;
   logic        decode_stall, ma_active, bus_grant_ma, bus_grant_fetch;
   logic        mul_start, mul_signed, mul_long_result, mul_busy, acc_access;
   logic [67:0] notes[$];
   logic [67:0] n;
   int          fail_count, comparisons;
   int          seed = 32'h4996;
   mul_interlock i_dut (.sys_clk, .sys_rst, .ex_valid, .ex_opclass, .ex_op_a, .ex_op_b,
      .fetch_req, .bus_ready, .decode_stall, .ma_active, .bus_grant_ma, .bus_grant_fetch,
      .mul_start, .mul_signed, .mul_long_result, .mul_a, .mul_b, .mul_busy, .acc_access);
   initial begin
      sys_clk = 0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input string s, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // issue one class once the access sequencer is free
   task automatic issue(input logic [3:0] c);
      for (int i = 0; i < 200 && ma_active !== 1'b0; i++) @(negedge sys_clk);
      ex_valid = 1;
      ex_opclass = c;
      ex_op_a = $random(seed);
      ex_op_b = $random(seed);
      @(negedge sys_clk);
      if (c != 0) notes.push_back({c, ex_op_a, ex_op_b});
      ex_valid = 0;
   endtask
   // random bus traffic stalls the access stages
   always @(negedge sys_clk) begin
      fetch_req <= 1'($random(seed));
      bus_ready <= 1'($random(seed));
   end
   // registered pulses are sampled mid-cycle, away from the edge that launches them
   always @(negedge sys_clk) begin
      if (!sys_rst && (mul_start || acc_access)) begin
         check("pending", notes.size() != 0, 1);
         n = notes.pop_front();
         if (mul_start) begin
            check("mul_a", mul_a, n[63:32]);
            check("mul_b", mul_b, n[31:0]);
            check("long", mul_long_result, n[67:64] != 3);
            if (n[67:64] != 3) check("signed", mul_signed, n[67:64] == 1);
         end else check("single", n[67:64] > 3, 1);
      end
   end
   initial begin
      {ex_valid, fetch_req, bus_ready, ex_opclass, ex_op_a, ex_op_b} = '0;
      sys_rst = 1;
      repeat (20) @(negedge sys_clk);
      sys_rst = 0;
      // each double followed by every class, so followers collide with busy
      for (int t = 1; t < 4; t++) begin
         for (int f = 0; f < 11; f++) begin
            issue(t);
            issue(f);
         end
         $display("test %0d done", t);
      end
      issue(1);
      sys_rst = 1;
      notes.delete();
      repeat (2) @(negedge sys_clk);
      sys_rst = 0;
      issue(2);
      issue(10);
      repeat (40) @(negedge sys_clk);
      check("left", notes.size(), 0);
      $display("test 4 done");
      conclude();
   end
   initial begin
      #250000;
      fail_count++;
      conclude();
   end
endmodule
